// >>> hw/icu_top.sv
// The AXI4-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
module icu_top
    import icu_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int FIFO_DEPTH = 4
)
(
    input wire logic CLK, // Module clock, 100 MHz
    input wire logic RESETN, // Async reset, active low
    input wire logic [ADDR_W-1:0] AWADDR, // Write address
    input wire logic [2:0] AWPROT, // Write protection, unused
    input wire logic AWVALID, // Write address valid
    output logic AWREADY, // Write address ready
    input wire logic [31:0] WDATA, // Write data
    input wire logic [3:0] WSTRB, // Write byte strobes
    input wire logic WVALID, // Write data valid
    output logic WREADY, // Write data ready
    output logic [1:0] BRESP, // Write response
    output logic BVALID, // Write response valid
    input wire logic BREADY, // Write response ready
    input wire logic [ADDR_W-1:0] ARADDR, // Read address
    input wire logic [2:0] ARPROT, // Read protection, unused
    input wire logic ARVALID, // Read address valid
    output logic ARREADY, // Read address ready
    output logic [31:0] RDATA, // Read data
    output logic [1:0] RRESP, // Read response
    output logic RVALID, // Read data valid
    input wire logic RREADY, // Read data ready
    input wire logic CAP_PIN, // Dedicated capture pin, async
    input wire logic [2:0] CMP_IN, // Comparator outputs 1..3, async
    input wire logic GATE_IN, // Gating source, async
    output logic [ICU_OE_W-1:0] OUT_EN, // Output steering enables in force
    output logic AUX_OUT // Auxiliary event output
);
    localparam int AW = $clog2(FIFO_DEPTH);

    // Refuse sizes the pointers cannot serve
    initial
    begin
        if (FIFO_DEPTH < 2 || (1 << AW) != FIFO_DEPTH || ADDR_W < 5)
            $error("icu_top: FIFO_DEPTH must be a power of two >= 2, ADDR_W >= 5");
    end

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
        hit = ({{(ADDR_W-2){1'b0}}, a[ADDR_W-1:2]} == {{(ADDR_W-2){1'b0}}, off[7:2]}) &&
              (ADDR_W == 8 || a[ADDR_W-1:(ADDR_W > 8 ? 8 : ADDR_W-1)] == '0 || ADDR_W < 8);
    endfunction

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    // Register state
    logic [15:0] con1l_r;
    logic [15:0] con2h_r;
    logic [31:0] tb_r;
    logic [31:0] tmr_sync_r;
    logic [ICU_OE_W-1:0] oe_eff_r;
    logic aux_r;
    logic ovf_r;
    logic dis_r;
    logic [3:0] presc_r;
    logic src_prev_r;
    logic gate_prev_r;
    logic [ICU_SYNC_IN_W-1:0] sync1_r;
    logic [ICU_SYNC_IN_W-1:0] sync2_r;
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] cnt_r;
    logic aw_hold_r;
    logic w_hold_r;
    logic [ADDR_W-1:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    icu_rd_state_t rd_state_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic buf_sel_r;
    logic [31:0] mem_q;

    // Control fields
    wire [3:0] mode = con1l_r[ICU_MOD_LSB +: 4];
    wire capture_select = con1l_r[ICU_CAPTURE_SELECT_BIT];
    wire t32 = con1l_r[ICU_T32_BIT];
    wire output_enable_sync = con2h_r[ICU_OUTPUT_ENABLE_SYNC_BIT];
    wire [1:0] gsm = con2h_r[ICU_GSM_LSB +: 2];
    wire [1:0] auxsel = con2h_r[ICU_AUX_LSB +: 2];
    wire [2:0] ics = con2h_r[ICU_ICS_LSB +: 3];

    // Two-stage synchronisers for every asynchronous input
    genvar gi;
    generate
        for (gi = 0; gi < ICU_SYNC_IN_W; gi++)
        begin : g_sync
            always_ff @(posedge CLK or negedge RESETN)
            begin
                if (!RESETN)
                begin
                    sync1_r[gi] <= 1'b0;
                    sync2_r[gi] <= 1'b0;
                end
                else
                begin
                    sync1_r[gi] <= (gi == 0) ? CAP_PIN : (gi == 4) ? GATE_IN : CMP_IN[(gi + 2) % 3];
                    sync2_r[gi] <= sync1_r[gi];
                end
            end
        end
    endgenerate

    // Source and gate selection, edge detection
    wire src_s = (ics == ICU_ICS_PIN) ? sync2_r[0] :
                 (ics == ICU_ICS_CMP1) ? sync2_r[1] :
                 (ics == ICU_ICS_CMP2) ? sync2_r[2] :
                 (ics == ICU_ICS_CMP3) ? sync2_r[3] : 1'b0;
    wire gate_s = sync2_r[4];
    wire rise = src_s & ~src_prev_r;
    wire fall = ~src_s & src_prev_r;
    wire gate_rise = gate_s & ~gate_prev_r;
    wire gate_fall = ~gate_s & gate_prev_r;

    // Mode decode; unlisted codes never capture
    wire mode_ev = (mode == ICU_MODE_EDGE) ? (rise | fall) :
                   (mode == ICU_MODE_RISE) ? rise :
                   (mode == ICU_MODE_FALL) ? fall :
                   (mode == ICU_MODE_BOTH) ? (rise | fall) :
                   (mode == ICU_MODE_DIV4) ? (rise & (presc_r[1:0] == 2'h3)) :
                   (mode == ICU_MODE_DIV16) ? (rise & (presc_r == 4'hf)) : 1'b0;
    wire cap_en = (gsm == ICU_GSM_LEVEL) ? gate_s : ~dis_r;
    wire fire = capture_select & cap_en & mode_ev;

    // Time base: 16-bit mode wraps at the low half so the high half stays zero
    wire tb_wrap = capture_select & (t32 ? (&tb_r) : (&tb_r[15:0]));
    // Narrow mode drops the high half, even if wide counting left it set
    wire [31:0] tb_inc = t32 ? tb_r + 32'h1 : {16'h0, tb_r[15:0] + 16'h1};
    wire [31:0] tb_nxt = (!capture_select || tb_wrap) ? 32'h0 : tb_inc;
    wire [31:0] cap_val = t32 ? tb_r : {16'h0, tb_r[15:0]};

    // FIFO bookkeeping; a capture into a full FIFO is dropped and flagged
    wire empty = (cnt_r == '0);
    wire full = (cnt_r == FIFO_DEPTH[AW:0]);
    wire push = fire & ~full;
    wire ar_hs = ARVALID & ARREADY;
    wire pop = ar_hs & hit(ARADDR, ICU_OFF_BUF) & ~empty;
    wire [AW:0] cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

    // Write path decode
    wire do_write = aw_hold_r & w_hold_r & ~bvalid_r;
    wire w_con1l = do_write & hit(awaddr_r, ICU_OFF_CON1L);
    wire w_con2h = do_write & hit(awaddr_r, ICU_OFF_CON2H);
    wire w_stat = do_write & hit(awaddr_r, ICU_OFF_STAT);
    wire w_ro = do_write & (hit(awaddr_r, ICU_OFF_TMRL) | hit(awaddr_r, ICU_OFF_TMRH) |
                            hit(awaddr_r, ICU_OFF_BUF));
    wire w_ok = w_con1l | w_con2h | w_stat | w_ro;
    wire ovf_clr = w_stat & wstrb_r[0] & wdata_r[ICU_ST_OVF];

    // Read path decode
    wire [31:0] stat_word = {{(23-AW){1'b0}}, cnt_r, 4'h0, dis_r, ovf_r, full, empty};
    wire r_known = hit(ARADDR, ICU_OFF_CON1L) | hit(ARADDR, ICU_OFF_CON2H) |
                   hit(ARADDR, ICU_OFF_TMRL) | hit(ARADDR, ICU_OFF_TMRH) |
                   hit(ARADDR, ICU_OFF_BUF) | hit(ARADDR, ICU_OFF_STAT);
    wire [31:0] r_mux = hit(ARADDR, ICU_OFF_CON1L) ? {16'h0, con1l_r} :
                        hit(ARADDR, ICU_OFF_CON2H) ? {16'h0, con2h_r} :
                        hit(ARADDR, ICU_OFF_TMRL) ? {16'h0, tmr_sync_r[15:0]} :
                        hit(ARADDR, ICU_OFF_TMRH) ? {16'h0, tmr_sync_r[31:16]} :
                        hit(ARADDR, ICU_OFF_STAT) ? stat_word : 32'h0;

    // Bus handshakes; a held channel blocks its next beat until the write completes
    assign AWREADY = ~aw_hold_r;
    assign WREADY = ~w_hold_r;
    assign BVALID = bvalid_r;
    assign BRESP = bresp_r;
    assign ARREADY = (rd_state_r == ICU_RD_IDLE);
    assign RVALID = (rd_state_r == ICU_RD_RESP);
    assign RRESP = rresp_r;
    assign RDATA = buf_sel_r ? mem_q : rdata_r;
    assign OUT_EN = oe_eff_r;
    assign AUX_OUT = aux_r;

    // Write channel capture and response
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= 32'h0;
            wstrb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= ICU_RESP_OKAY;
        end
        else
        begin
            if (AWVALID && !aw_hold_r)
            begin
                aw_hold_r <= 1'b1;
                awaddr_r <= AWADDR;
            end
            if (WVALID && !w_hold_r)
            begin
                w_hold_r <= 1'b1;
                wdata_r <= WDATA;
                wstrb_r <= WSTRB;
            end
            if (do_write)
            begin
                aw_hold_r <= 1'b0;
                w_hold_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= w_ok ? ICU_RESP_OKAY : ICU_RESP_SLVERR;
            end
            else if (BREADY)
                bvalid_r <= 1'b0;
        end
    end

    // Read channel; FIFO reads take their data straight from the storage register
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            rd_state_r <= ICU_RD_IDLE;
            rdata_r <= 32'h0;
            rresp_r <= ICU_RESP_OKAY;
            buf_sel_r <= 1'b0;
        end
        else
        begin
            case (rd_state_r)
                ICU_RD_IDLE:
                begin
                    if (ARVALID)
                    begin
                        rd_state_r <= ICU_RD_RESP;
                        rdata_r <= r_mux;
                        rresp_r <= r_known ? ICU_RESP_OKAY : ICU_RESP_SLVERR;
                        buf_sel_r <= pop;
                    end
                end
                ICU_RD_RESP:
                begin
                    if (RREADY)
                    begin
                        rd_state_r <= ICU_RD_IDLE;
                        buf_sel_r <= 1'b0;
                    end
                    else if (buf_sel_r)
                    begin
                        // Storage output follows the moved pointer, so keep the popped word
                        rdata_r <= mem_q;
                        buf_sel_r <= 1'b0;
                    end
                end
                default:
                    rd_state_r <= ICU_RD_IDLE;
            endcase
        end
    end

    // Control registers; reserved bits stay zero
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            con1l_r <= ICU_CON1L_RST;
            con2h_r <= ICU_CON2H_RST;
        end
        else
        begin
            if (w_con1l)
                con1l_r <= merge16(con1l_r, wdata_r, wstrb_r) & ICU_CON1L_MASK;
            if (w_con2h)
                con2h_r <= merge16(con2h_r, wdata_r, wstrb_r) & ICU_CON2H_MASK;
        end
    end

    // Time base, read-back copy, steering enables, auxiliary output
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            tb_r <= 32'h0;
            tmr_sync_r <= 32'h0;
            oe_eff_r <= ICU_CON2H_RST[ICU_OE_LSB +: ICU_OE_W];
            aux_r <= 1'b0;
        end
        else
        begin
            tb_r <= tb_nxt;
            tmr_sync_r <= tb_r;
            if (!output_enable_sync || tb_wrap || !capture_select)
                oe_eff_r <= con2h_r[ICU_OE_LSB +: ICU_OE_W];
            aux_r <= (auxsel == ICU_AUX_ROLL) ? tb_wrap :
                     (auxsel == ICU_AUX_MODE) ? fire : 1'b0;
        end
    end

    // Edge history, prescaler, one-shot gate, overflow flag (set wins over clear)
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            src_prev_r <= 1'b0;
            gate_prev_r <= 1'b0;
            presc_r <= 4'h0;
            dis_r <= 1'b0;
            ovf_r <= 1'b0;
        end
        else
        begin
            src_prev_r <= src_s;
            gate_prev_r <= gate_s;
            if (!capture_select)
                presc_r <= 4'h0;
            else if (rise)
                presc_r <= presc_r + 4'h1;
            if (!capture_select)
                dis_r <= (gsm == ICU_GSM_RISE_EN); // Rising-edge one-shot waits for its edge
            else if (gsm == ICU_GSM_RISE_EN && gate_rise)
                dis_r <= 1'b0;
            else if (gsm != ICU_GSM_LEVEL && gsm != ICU_GSM_RISE_EN && gate_fall)
                dis_r <= 1'b1;
            if (fire && full)
                ovf_r <= 1'b1;
            else if (ovf_clr)
                ovf_r <= 1'b0;
        end
    end

    // FIFO pointers
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            cnt_r <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_r <= wr_ptr_r + 1'b1;
            if (pop)
                rd_ptr_r <= rd_ptr_r + 1'b1;
            cnt_r <= cnt_nxt;
        end
    end

    icu_mem #(.WIDTH(32), .DEPTH(FIFO_DEPTH), .AW(AW)) u_mem
    (
        .clk(CLK),
        .resetn(RESETN),
        .we(push),
        .waddr(wr_ptr_r),
        .wdata(cap_val),
        .raddr(rd_ptr_r),
        .rdata(mem_q)
    );

    // Checks
    a_push_count: assert property (@(posedge CLK) disable iff (!RESETN)
        push && !pop |=> cnt_r == $past(cnt_r) + 1'b1) else $error("capture not stored");
    a_sel_gates: assert property (@(posedge CLK) disable iff (!RESETN)
        !capture_select |-> !fire && tb_nxt == 32'h0) else $error("capture while deselected");
    a_rise_only: assert property (@(posedge CLK) disable iff (!RESETN)
        fire && mode == ICU_MODE_RISE |-> src_s && !src_prev_r) else $error("non-rising capture");
    a_fall_only: assert property (@(posedge CLK) disable iff (!RESETN)
        fire && mode == ICU_MODE_FALL |-> !src_s && src_prev_r) else $error("non-falling capture");
    a_both_edges: assert property (@(posedge CLK) disable iff (!RESETN)
        capture_select && cap_en && mode == ICU_MODE_BOTH && (src_s != src_prev_r) |-> fire) else $error("edge missed");
    a_div_sixteen: assert property (@(posedge CLK) disable iff (!RESETN)
        fire && mode == ICU_MODE_DIV16 |=> presc_r == 4'h0) else $error("divide by 16 slip");
    a_narrow_base: assert property (@(posedge CLK) disable iff (!RESETN)
        !t32 |=> tb_r[31:16] == 16'h0) else $error("high half counts in 16-bit mode");
    a_tmr_lag: assert property (@(posedge CLK) disable iff (!RESETN)
        ##2 tmr_sync_r == $past(tb_r, 1)) else $error("timer read-back lag wrong");
    a_oe_hold: assert property (@(posedge CLK) disable iff (!RESETN)
        output_enable_sync && capture_select && !tb_wrap |=> $stable(oe_eff_r)) else $error("enable moved early");
    a_level_gate: assert property (@(posedge CLK) disable iff (!RESETN)
        gsm == ICU_GSM_LEVEL && !gate_s |-> !fire) else $error("capture while gated");
    a_aux_mode: assert property (@(posedge CLK) disable iff (!RESETN)
        auxsel == ICU_AUX_MODE |=> AUX_OUT == $past(fire)) else $error("aux does not follow capture");
    a_pop_read: assert property (@(posedge CLK) disable iff (!RESETN)
        pop && !push |=> cnt_r == $past(cnt_r) - 1'b1 ##0 RVALID) else $error("read did not remove");

    c_wide_capture: cover property (@(posedge CLK) disable iff (!RESETN) push && t32);
    c_fifo_full: cover property (@(posedge CLK) disable iff (!RESETN) fire && full);
    c_buf_read: cover property (@(posedge CLK) disable iff (!RESETN) pop ##1 RVALID && RREADY);
    c_rollover: cover property (@(posedge CLK) disable iff (!RESETN) tb_wrap && !t32);
endmodule

// >>> hw/icu_pkg.sv
package icu_pkg;
    // Register byte offsets
    localparam logic [7:0] ICU_OFF_CON1L = 8'h00;
    localparam logic [7:0] ICU_OFF_CON2H = 8'h04;
    localparam logic [7:0] ICU_OFF_TMRL = 8'h08;
    localparam logic [7:0] ICU_OFF_TMRH = 8'h0c;
    localparam logic [7:0] ICU_OFF_BUF = 8'h10;
    localparam logic [7:0] ICU_OFF_STAT = 8'h14;

    // First control register fields
    localparam int ICU_MOD_LSB = 0;
    localparam int ICU_CAPTURE_SELECT_BIT = 4;
    localparam int ICU_T32_BIT = 5;
    localparam logic [15:0] ICU_CON1L_RST = 16'h0000;
    localparam logic [15:0] ICU_CON1L_MASK = 16'h003f;

    // Second control register, high half, fields
    localparam int ICU_OUTPUT_ENABLE_SYNC_BIT = 15;
    localparam int ICU_OE_LSB = 8;
    localparam int ICU_OE_W = 6;
    localparam int ICU_GSM_LSB = 6;
    localparam int ICU_AUX_LSB = 3;
    localparam int ICU_ICS_LSB = 0;
    localparam logic [15:0] ICU_CON2H_RST = 16'h0100;
    localparam logic [15:0] ICU_CON2H_MASK = 16'hbfdf;

    // Status register fields
    localparam int ICU_ST_EMPTY = 0;
    localparam int ICU_ST_FULL = 1;
    localparam int ICU_ST_OVF = 2;
    localparam int ICU_ST_DIS = 3;
    localparam int ICU_ST_CNT_LSB = 8;

    // Capture modes
    localparam logic [3:0] ICU_MODE_EDGE = 4'h0;
    localparam logic [3:0] ICU_MODE_RISE = 4'h1;
    localparam logic [3:0] ICU_MODE_FALL = 4'h2;
    localparam logic [3:0] ICU_MODE_BOTH = 4'h3;
    localparam logic [3:0] ICU_MODE_DIV4 = 4'h4;
    localparam logic [3:0] ICU_MODE_DIV16 = 4'h5;

    // Gating modes, auxiliary output and source selects
    localparam logic [1:0] ICU_GSM_LEVEL = 2'h0;
    localparam logic [1:0] ICU_GSM_RISE_EN = 2'h1;
    localparam logic [1:0] ICU_AUX_ROLL = 2'h1;
    localparam logic [1:0] ICU_AUX_MODE = 2'h2;
    localparam logic [2:0] ICU_ICS_PIN = 3'h0;
    localparam logic [2:0] ICU_ICS_CMP1 = 3'h1;
    localparam logic [2:0] ICU_ICS_CMP2 = 3'h2;
    localparam logic [2:0] ICU_ICS_CMP3 = 3'h3;

    // Bus answers and misc
    localparam logic [1:0] ICU_RESP_OKAY = 2'h0;
    localparam logic [1:0] ICU_RESP_SLVERR = 2'h2;
    localparam int ICU_SYNC_IN_W = 5;

    typedef enum logic {ICU_RD_IDLE, ICU_RD_RESP} icu_rd_state_t;
endpackage

// >>> hw/icu_mem.sv
`timescale 1ns/1ps
// Capture storage; read data leave through a register
module icu_mem
#(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4,
    parameter int AW = 2
)
(
    input wire logic clk, // Module clock
    input wire logic resetn, // Async reset, active low
    input wire logic we, // Write strobe
    input wire logic [AW-1:0] waddr, // Write address
    input wire logic [WIDTH-1:0] wdata, // Write data
    input wire logic [AW-1:0] raddr, // Read address
    output logic [WIDTH-1:0] rdata // Registered read data
);
    logic [WIDTH-1:0] mem_r [DEPTH];

    // Array carries no reset, so it maps onto plain storage
    always_ff @(posedge clk)
    begin
        if (we)
            mem_r[waddr] <= wdata;
    end

    // Registered read port
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            rdata <= '0;
        else
            rdata <= mem_r[raddr];
    end
endmodule

// >>> verif/icu_src_model.sv
`timescale 1ns/1ps
// Event sources at the far side: capture pin, comparators, gating line
module icu_src_model
(
    input wire logic clk, // Module clock
    output logic cap_pin, // Capture pin
    output logic [2:0] cmp, // Comparator outputs
    output logic gate // Gating source
);
    // Quiet low lines, gate open
    initial
    begin
        cap_pin = 1'b0;
        cmp = 3'h0;
        gate = 1'b1;
    end
    // Level of the gating source
    task automatic set_gate(input logic g);
        gate <= g;
    endtask
    // Pulses on the lines picked by sel; each level held long enough to pass the synchroniser
    task automatic pulses(input logic [3:0] sel, input int n, input int hold);
        repeat (n)
        begin
            repeat (hold) @(posedge clk);
            cap_pin <= sel[0];
            cmp <= sel[3:1];
            repeat (hold) @(posedge clk);
            cap_pin <= 1'b0;
            cmp <= 3'h0;
        end
        repeat (hold) @(posedge clk);
    endtask
endmodule

// >>> verif/icu_top_tb.sv
`timescale 1ns/1ps
// Bench: bus master tasks, source model, one task a scenario
module icu_top_tb;
    import icu_pkg::*;
    logic CLK, RESETN, AWVALID, WVALID, BREADY, ARVALID, RREADY;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID, CAP_PIN, GATE_IN, AUX_OUT;
    logic [7:0] AWADDR, ARADDR;
    logic [31:0] WDATA, RDATA, rd, rd2;
    logic [1:0] BRESP, RRESP, rsp;
    logic [2:0] CMP_IN;
    logic [5:0] OUT_EN;
    int n_mismatch = 0;
    int samples_checked = 0;
    int n_aux = 0;
    int aux0;

    icu_top #(.ADDR_W(8), .FIFO_DEPTH(8)) i_dut
    (
        .CLK(CLK), .RESETN(RESETN), .AWADDR(AWADDR), .AWPROT(3'h0), .AWVALID(AWVALID), .AWREADY(AWREADY),
        .WDATA(WDATA), .WSTRB(4'hf), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
        .BREADY(BREADY), .ARADDR(ARADDR), .ARPROT(3'h0), .ARVALID(ARVALID), .ARREADY(ARREADY),
        .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY), .CAP_PIN(CAP_PIN),
        .CMP_IN(CMP_IN), .GATE_IN(GATE_IN), .OUT_EN(OUT_EN), .AUX_OUT(AUX_OUT)
    );
    icu_src_model i_src (.clk(CLK), .cap_pin(CAP_PIN), .cmp(CMP_IN), .gate(GATE_IN));

    // Auxiliary pulses seen, one count per high cycle
    always @(negedge CLK)
        if (AUX_OUT === 1'b1)
            n_aux++;
    // 100 MHz clock
    initial
    begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end
    task automatic give_verdict();
        if (n_mismatch == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Four-state compare, so an unknown never matches
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            n_mismatch++;
        end
    endtask
    // Handshakes judged at the negedge, where ready has settled, then acted on at the next posedge
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        logic aw, w, b;
        n = 0;
        b = 1'b0;
        AWADDR <= a;
        WDATA <= d;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        BREADY <= 1'b1;
        while (!b)
        begin
            @(negedge CLK);
            aw = AWVALID & AWREADY;
            w = WVALID & WREADY;
            b = BVALID === 1'b1;
            r = BRESP;
            @(posedge CLK);
            if (aw)
                AWVALID <= 1'b0;
            if (w)
                WVALID <= 1'b0;
            if (++n > 100)
            begin
                n_mismatch++;
                give_verdict();
            end
        end
        BREADY <= 1'b0;
        @(posedge CLK);
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        logic ar, v;
        n = 0;
        v = 1'b0;
        ARADDR <= a;
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        while (!v)
        begin
            @(negedge CLK);
            ar = ARVALID & ARREADY;
            v = RVALID === 1'b1;
            d = RDATA;
            r = RRESP;
            @(posedge CLK);
            if (ar)
                ARVALID <= 1'b0;
            if (++n > 100)
            begin
                n_mismatch++;
                give_verdict();
            end
        end
        RREADY <= 1'b0;
        @(posedge CLK);
    endtask
    // Reset values and unmapped places
    task automatic t_reset_bus();
        axi_rd(ICU_OFF_CON2H, rd, rsp);
        chk(rd, 32'h100);
        chk({26'h0, OUT_EN}, 32'h1);
        axi_rd(8'h18, rd, rsp);
        chk({rd[29:0], rsp}, {30'h0, ICU_RESP_SLVERR});
        axi_wr(8'h20, 32'h0, rsp);
        chk({30'h0, rsp}, {30'h0, ICU_RESP_SLVERR});
    endtask
    // Steering applies at once, or waits for a time base reset when synchronised
    task automatic t_oe();
        axi_wr(ICU_OFF_CON2H, 32'h3f00, rsp);
        repeat (3) @(posedge CLK);
        chk({26'h0, OUT_EN}, 32'h3f);
        axi_wr(ICU_OFF_CON1L, 32'h11, rsp);
        axi_wr(ICU_OFF_CON2H, 32'h8100, rsp);
        repeat (20) @(posedge CLK);
        chk({26'h0, OUT_EN}, 32'h3f);
        axi_wr(ICU_OFF_CON1L, 32'h0, rsp);
        repeat (5) @(posedge CLK);
        chk({26'h0, OUT_EN}, 32'h1);
        axi_wr(ICU_OFF_CON2H, 32'h100, rsp);
    endtask
    // Two rises 20 cycles apart: oldest read first, spacing equals timer steps
    task automatic t_order();
        axi_wr(ICU_OFF_CON1L, 32'h11, rsp);
        axi_wr(ICU_OFF_CON2H, 32'h110, rsp);
        aux0 = n_aux;
        i_src.pulses(4'h1, 2, 10);
        chk(n_aux - aux0, 32'd2);
        axi_rd(ICU_OFF_TMRH, rd, rsp);
        chk(rd, 32'h0);
        axi_rd(ICU_OFF_BUF, rd, rsp);
        axi_rd(ICU_OFF_BUF, rd2, rsp);
        chk({16'h0, rd2[15:0] - rd[15:0]}, 32'd20);
        axi_rd(ICU_OFF_STAT, rd, rsp);
        chk({31'h0, rd[ICU_ST_EMPTY]}, 32'h1);
        axi_wr(ICU_OFF_CON1L, 32'h0, rsp);
    endtask
    // Count the captures that n pulses give under one setup, then drain them
    task automatic t_case(input logic [5:0] c1, input logic [2:0] src, input logic [3:0] sel,
        input logic g, input int n, input logic [3:0] exp);
        axi_wr(ICU_OFF_CON1L, 32'h0, rsp);
        axi_wr(ICU_OFF_CON2H, 32'h100 | {29'h0, src}, rsp);
        axi_wr(ICU_OFF_CON1L, {26'h0, c1}, rsp);
        i_src.set_gate(g);
        i_src.pulses(sel, n, 4);
        axi_rd(ICU_OFF_STAT, rd, rsp);
        chk({28'h0, rd[11:8]}, {28'h0, exp});
        repeat (exp) axi_rd(ICU_OFF_BUF, rd, rsp);
        axi_rd(ICU_OFF_STAT, rd, rsp);
        chk({31'h0, rd[ICU_ST_EMPTY]}, 32'h1);
    endtask
    initial
    begin
        RESETN = 1'b0;
        AWVALID = 1'b0;
        WVALID = 1'b0;
        BREADY = 1'b0;
        ARVALID = 1'b0;
        RREADY = 1'b0;
        AWADDR = 8'h0;
        ARADDR = 8'h0;
        WDATA = 32'h0;
        repeat (6) @(posedge CLK);
        RESETN <= 1'b1;
        t_reset_bus();
        t_oe();
        t_order();
        t_case(6'h10, 3'h0, 4'h1, 1'b1, 4, 4'd8);
        t_case(6'h11, 3'h0, 4'h1, 1'b1, 4, 4'd4);
        t_case(6'h12, 3'h0, 4'h1, 1'b1, 4, 4'd4);
        t_case(6'h13, 3'h0, 4'h1, 1'b1, 4, 4'd8);
        t_case(6'h14, 3'h0, 4'h1, 1'b1, 4, 4'd1);
        t_case(6'h15, 3'h0, 4'h1, 1'b1, 16, 4'd1);
        t_case(6'h35, 3'h0, 4'h1, 1'b1, 15, 4'd0);
        t_case(6'h33, 3'h0, 4'h1, 1'b1, 4, 4'd8);
        t_case(6'h01, 3'h0, 4'h1, 1'b1, 4, 4'd0);
        t_case(6'h11, 3'h0, 4'h1, 1'b0, 4, 4'd0);
        t_case(6'h11, 3'h2, 4'h1, 1'b1, 4, 4'd0);
        t_case(6'h11, 3'h2, 4'h4, 1'b1, 4, 4'd4);
        give_verdict();
    end
endmodule
